// >>> logic/mem_map_pkg.sv
// package for the memory page and space map
// assumes a single mclk domain, driven by the cpu fetch/execute logic
package mem_map_pkg;
   // ************************************************
   // program memory geometry
   // ************************************************
   localparam int         PAGE_ADDR_W     = 16;
   localparam int         PROG_ADDR_W     = 18;
   localparam int         TABLE_PAGE_W    = 2;
   // ************************************************
   // data spaces
   // ************************************************
   localparam int         XRAM_ADDR_W     = 13;
   localparam logic [15:0] XRAM_LAST      = 16'h1FFF;
   localparam logic [7:0] SFR_BASE        = 8'h80;
   localparam int         SCRATCH_DEPTH   = 256;
   localparam int         XRAM_DEPTH      = 8192;
   // ************************************************
   // register offsets on the command port
   // ************************************************
   localparam logic [7:0] OFS_PTR_LOW     = 8'h82;
   localparam logic [7:0] OFS_PTR_HIGH    = 8'h83;
   localparam logic [7:0] OFS_ALT_LOW     = 8'h84;
   localparam logic [7:0] OFS_ALT_HIGH    = 8'h85;
   localparam logic [7:0] OFS_PAIR_SEL    = 8'h86;
   localparam logic [7:0] OFS_PAGE_CTRL   = 8'h92;
   // page control fields
   localparam int         POS_FETCH_PAGE  = 0;
   localparam int         POS_TABLE_LO    = 1;
   localparam int         POS_TABLE_HI    = 2;
   localparam int         POS_XRAM_EN     = 3;
   // reset values
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam logic [7:0] RST_PAGE_CTRL   = 8'h08;
   // extra opcode: decrement pointer
   localparam logic [7:0] OP_DEC_POINTER  = 8'hA5;
   // ************************************************
   // access kinds from the cpu
   // ************************************************
   typedef enum logic [3:0] {
      ACC_IDLE     = 4'b0001,
      ACC_DIRECT   = 4'b0010,
      ACC_INDIRECT = 4'b0100,
      ACC_EXT_DATA = 4'b1000
   } access_t;
endpackage

// >>> logic/mem_page_space_map.sv
// memory page selection, data space routing and data pointer pairs
// assumes the cpu drives one data access per cycle, synchronous to mclk
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module mem_page_space_map
   import mem_map_pkg::*;
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   reset,
   // instruction fetch
   input  wire logic [PAGE_ADDR_W-1:0] pc,
   output logic      [PROG_ADDR_W-1:0] fetch_addr,
   // table read
   input  wire logic                   table_read,
   input  wire logic [PAGE_ADDR_W-1:0] table_addr_in,
   output logic      [PROG_ADDR_W-1:0] table_addr,
   // data access
   input  wire access_t                acc_kind,
   input  wire logic [15:0]            acc_addr,
   input  wire logic                   acc_write,
   input  wire logic                   acc_bit,
   input  wire logic [2:0]             acc_bit_pos,
   input  wire logic [7:0]             acc_wdata,
   output logic      [7:0]             acc_rdata,
   output logic                        acc_miss,
   // executed opcode strobe
   input  wire logic                   op_strobe,
   input  wire logic [7:0]             op_code,
   // register command port
   input  wire logic [7:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [7:0]             reg_rdata,
   // active data pointer
   output logic      [15:0]            data_pointer_16
);
   // ************************************************
   // state
   // ************************************************
   logic [7:0]  ptr_low_reg;
   logic [7:0]  ptr_high_reg;
   logic [7:0]  alt_pointer_low_reg;
   logic [7:0]  alt_pointer_high_reg;
   logic        pointer_pair_select_reg;
   logic        fetch_page_sel_reg;
   logic        table_page_lo_reg;
   logic        table_page_hi_reg;
   logic        xram_en_reg;
   logic [7:0]  scratch [SCRATCH_DEPTH];
   logic [7:0]  xram    [XRAM_DEPTH];
   logic [15:0] ptr_next;
   logic [7:0]  sfr_wval;
   logic [7:0]  sfr_rval;
   logic [7:0]  acc_sfr_val;
   logic [7:0]  merged;
   logic        sfr_wr;
   logic        sfr_sel;
   logic        scr_sel;
   logic        xram_sel;
   logic [7:0]  wr_addr;
   logic [7:0]  rd_sel;

   // ************************************************
   // program addresses
   // ************************************************
   // page bit 1 of fetch is forced low: only pages 0 and 1
   always_comb
   begin
      fetch_addr = {1'b0, fetch_page_sel_reg, pc};
   end

   always_comb
   begin
      table_addr = table_read ? {table_page_hi_reg, table_page_lo_reg, table_addr_in}
                              : {TABLE_PAGE_W'(0), table_addr_in};
   end

   // ************************************************
   // data space decode
   // ************************************************
   always_comb
   begin
      sfr_sel  = (acc_kind == ACC_DIRECT) && (acc_addr[7:0] >= SFR_BASE);
      scr_sel  = (acc_kind == ACC_INDIRECT) ||
                 ((acc_kind == ACC_DIRECT) && (acc_addr[7:0] < SFR_BASE));
      xram_sel = (acc_kind == ACC_EXT_DATA) && xram_en_reg &&
                 (acc_addr <= XRAM_LAST);
   end

   // active pointer and its decrement
   always_comb
   begin
      data_pointer_16 = pointer_pair_select_reg ? {alt_pointer_high_reg, alt_pointer_low_reg}
                                                : {ptr_high_reg, ptr_low_reg};
      ptr_next        = data_pointer_16 - 16'h0001;
   end

   // register write source: command port has priority over cpu direct write
   always_comb
   begin
      merged = acc_sfr_val;
      merged[acc_bit_pos] = acc_wdata[0];
      sfr_wr   = reg_wr || (sfr_sel && acc_write &&
                 (!acc_bit || (acc_addr[2:0] == 3'h0)));
      wr_addr  = reg_wr ? reg_addr : acc_addr[7:0];
      sfr_wval = reg_wr ? reg_wdata : (acc_bit ? merged : acc_wdata);
      rd_sel   = reg_rd ? reg_addr : acc_addr[7:0];
   end

   // register read value
   always_comb
   begin
      sfr_rval = RST_BYTE;
      unique case (rd_sel)
         OFS_PTR_LOW:   sfr_rval = ptr_low_reg;
         OFS_PTR_HIGH:  sfr_rval = ptr_high_reg;
         OFS_ALT_LOW:   sfr_rval = alt_pointer_low_reg;
         OFS_ALT_HIGH:  sfr_rval = alt_pointer_high_reg;
         OFS_PAIR_SEL:  sfr_rval = {7'h00, pointer_pair_select_reg};
         OFS_PAGE_CTRL: sfr_rval = {4'h0, xram_en_reg, table_page_hi_reg,
                                    table_page_lo_reg, fetch_page_sel_reg};
         default:       sfr_rval = RST_BYTE;
      endcase
   end

   // register value seen by cpu direct accesses
   always_comb
   begin
      acc_sfr_val = RST_BYTE;
      unique case (acc_addr[7:0])
         OFS_PTR_LOW:   acc_sfr_val = ptr_low_reg;
         OFS_PTR_HIGH:  acc_sfr_val = ptr_high_reg;
         OFS_ALT_LOW:   acc_sfr_val = alt_pointer_low_reg;
         OFS_ALT_HIGH:  acc_sfr_val = alt_pointer_high_reg;
         OFS_PAIR_SEL:  acc_sfr_val = {7'h00, pointer_pair_select_reg};
         OFS_PAGE_CTRL: acc_sfr_val = {4'h0, xram_en_reg, table_page_hi_reg,
                                       table_page_lo_reg, fetch_page_sel_reg};
         default:       acc_sfr_val = RST_BYTE;
      endcase
   end

   // ************************************************
   // pointer registers
   // ************************************************
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ptr_low_reg          <= RST_BYTE;
         ptr_high_reg         <= RST_BYTE;
         alt_pointer_low_reg  <= RST_BYTE;
         alt_pointer_high_reg <= RST_BYTE;
      end
      else if (op_strobe && (op_code == OP_DEC_POINTER))
      begin
         if (pointer_pair_select_reg)
         begin
            alt_pointer_low_reg  <= ptr_next[7:0];
            alt_pointer_high_reg <= ptr_next[15:8];
         end
         else
         begin
            ptr_low_reg  <= ptr_next[7:0];
            ptr_high_reg <= ptr_next[15:8];
         end
      end
      else if (sfr_wr)
      begin
         if (wr_addr == OFS_PTR_LOW)  ptr_low_reg          <= sfr_wval;
         if (wr_addr == OFS_PTR_HIGH) ptr_high_reg         <= sfr_wval;
         if (wr_addr == OFS_ALT_LOW)  alt_pointer_low_reg  <= sfr_wval;
         if (wr_addr == OFS_ALT_HIGH) alt_pointer_high_reg <= sfr_wval;
      end
   end

   // ************************************************
   // control registers
   // ************************************************
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         pointer_pair_select_reg <= 1'b0;
         fetch_page_sel_reg      <= RST_PAGE_CTRL[POS_FETCH_PAGE];
         table_page_lo_reg       <= RST_PAGE_CTRL[POS_TABLE_LO];
         table_page_hi_reg       <= RST_PAGE_CTRL[POS_TABLE_HI];
         xram_en_reg             <= RST_PAGE_CTRL[POS_XRAM_EN];
      end
      else if (sfr_wr)
      begin
         if (wr_addr == OFS_PAIR_SEL)
            pointer_pair_select_reg <= sfr_wval[0];
         if (wr_addr == OFS_PAGE_CTRL)
         begin
            fetch_page_sel_reg <= sfr_wval[POS_FETCH_PAGE];
            table_page_lo_reg  <= sfr_wval[POS_TABLE_LO];
            table_page_hi_reg  <= sfr_wval[POS_TABLE_HI];
            xram_en_reg        <= sfr_wval[POS_XRAM_EN];
         end
      end
   end

   // ************************************************
   // memories
   // ************************************************
   always_ff @(posedge mclk)
   begin
      if (scr_sel && acc_write)
         scratch[acc_addr[7:0]] <= acc_wdata;
      if (xram_sel && acc_write)
         xram[acc_addr[XRAM_ADDR_W-1:0]] <= acc_wdata;
   end

   // ************************************************
   // read data, one cycle after the request
   // ************************************************
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         acc_rdata <= RST_BYTE;
         acc_miss  <= 1'b0;
         reg_rdata <= RST_BYTE;
      end
      else
      begin
         reg_rdata <= reg_rd ? sfr_rval : RST_BYTE;
         acc_miss  <= (acc_kind == ACC_EXT_DATA) && !xram_sel;
         if (sfr_sel)
            acc_rdata <= acc_bit ? {7'h00, acc_sfr_val[acc_bit_pos]} : acc_sfr_val;
         else if (scr_sel)
            acc_rdata <= scratch[acc_addr[7:0]];
         else if (xram_sel)
            acc_rdata <= xram[acc_addr[XRAM_ADDR_W-1:0]];
         else
            acc_rdata <= RST_BYTE;
      end
   end

   // ************************************************
   // checks
   // ************************************************
   sequence s_dec_cmd;
      op_strobe && (op_code == OP_DEC_POINTER) && !sfr_wr;
   endsequence

   sequence s_page_write;
      reg_wr && (reg_addr == OFS_PAGE_CTRL);
   endsequence

   sequence s_bit_wr_low_ptr;
      (acc_kind == ACC_DIRECT) && acc_bit && acc_write && !reg_wr && !op_strobe &&
      (acc_addr[7:0] == OFS_PTR_LOW);
   endsequence

   a_fetch_page_low: assert property (@(posedge mclk) disable iff (reset)
      fetch_addr[PROG_ADDR_W-1] == 1'b0) else $error("fetch left pages 0-1");
   a_fetch_page_bit: assert property (@(posedge mclk) disable iff (reset)
      s_page_write |=> fetch_addr[PAGE_ADDR_W] == $past(reg_wdata[POS_FETCH_PAGE]))
      else $error("fetch page not taken from write");
   a_table_page: assert property (@(posedge mclk) disable iff (reset)
      table_read |-> table_addr[PROG_ADDR_W-1:PAGE_ADDR_W] ==
      {table_page_hi_reg, table_page_lo_reg}) else $error("bad table page");
   a_table_follow: assert property (@(posedge mclk) disable iff (reset)
      s_page_write ##1 !sfr_wr ##1 table_read |->
      table_addr[PROG_ADDR_W-1:PAGE_ADDR_W] == $past(reg_wdata[POS_TABLE_HI:POS_TABLE_LO], 2))
      else $error("table page not taken from write");
   a_pointer_dec: assert property (@(posedge mclk) disable iff (reset)
      s_dec_cmd |=> data_pointer_16 == $past(data_pointer_16) - 16'h0001)
      else $error("pointer not decremented");
   a_indirect_scr: assert property (@(posedge mclk) disable iff (reset)
      (acc_kind == ACC_INDIRECT) |-> scr_sel && !sfr_sel) else $error("indirect hit sfr");
   a_space_apart: assert property (@(posedge mclk) disable iff (reset)
      !(xram_sel && scr_sel)) else $error("spaces overlap");
   a_xram_disable: assert property (@(posedge mclk) disable iff (reset)
      (acc_kind == ACC_EXT_DATA && !xram_en_reg) |=> acc_miss)
      else $error("disabled ram answered");
   a_xram_window: assert property (@(posedge mclk) disable iff (reset)
      (acc_kind == ACC_EXT_DATA) && (acc_addr > XRAM_LAST) |=> acc_miss)
      else $error("access above data ram answered");
   a_pair_sel: assert property (@(posedge mclk) disable iff (reset)
      pointer_pair_select_reg |-> data_pointer_16 ==
      {alt_pointer_high_reg, alt_pointer_low_reg}) else $error("wrong pair");
   a_sfr_direct_rd: assert property (@(posedge mclk) disable iff (reset)
      (acc_kind == ACC_DIRECT) && !acc_bit && (acc_addr[7:0] == OFS_PTR_LOW) |=>
      acc_rdata == $past(ptr_low_reg)) else $error("direct register read wrong");
   a_bit_refused: assert property (@(posedge mclk) disable iff (reset)
      s_bit_wr_low_ptr |=> $stable(ptr_low_reg))
      else $error("bit write changed a byte register");
endmodule

// >>> verification/cpu_side_model.sv
// cpu side model: drives fetch, table, data access and opcode ports
// assumes the block samples on rising mclk and answers one cycle later
`timescale 1ns/1ps
module cpu_side_model
   import mem_map_pkg::*;
(
   // clock and results
   input  wire logic  mclk,
   input  wire logic  [7:0]  acc_rdata,
   input  wire logic  acc_miss,
   // fetch and table
   output logic       [15:0] pc,
   output logic       table_read,
   output logic       [15:0] table_addr_in,
   // data access
   output access_t    acc_kind,
   output logic       [15:0] acc_addr,
   output logic       acc_write,
   output logic       acc_bit,
   output logic       [2:0]  acc_bit_pos,
   output logic       [7:0]  acc_wdata,
   // opcode strobe
   output logic       op_strobe,
   output logic       [7:0]  op_code
);
   initial
   begin
      {pc, table_read, table_addr_in, acc_addr, acc_write} = '0;
      {acc_bit, acc_bit_pos, acc_wdata, op_strobe, op_code} = '0;
      acc_kind = ACC_IDLE;
   end
   task automatic fetch(input logic [15:0] p, input logic t, input logic [15:0] a);
      @(posedge mclk);
      pc <= p;
      table_read <= t;
      table_addr_in <= a;
      @(posedge mclk);
      #1;
   endtask
   // released address and data lines show inverted values, not the last ones; kind returns to idle and write to low
   task automatic access(input access_t k, input logic [15:0] a, input logic w,
      input logic [7:0] d, output logic [7:0] q, output logic m);
      @(posedge mclk);
      acc_kind <= k;
      acc_addr <= a;
      acc_write <= w;
      acc_wdata <= d;
      @(posedge mclk);
      acc_kind <= ACC_IDLE;
      acc_addr <= ~a;
      acc_write <= 1'b0;
      acc_wdata <= ~d;
      #1;
      q = acc_rdata;
      m = acc_miss;
   endtask
   task automatic set_bit(input logic b, input logic [2:0] p);
      @(posedge mclk);
      acc_bit <= b;
      acc_bit_pos <= p;
   endtask
   task automatic op(input logic [7:0] c);
      @(posedge mclk);
      op_strobe <= 1'b1;
      op_code <= c;
      @(posedge mclk);
      op_strobe <= 1'b0;
      op_code <= ~c;
      #1;
   endtask
endmodule

// >>> verification/memory_page_and_space_map_tb_top.sv
// testbench: command port tasks plus cpu model sequences
// assumes the block answers reads and data accesses one cycle later
`timescale 1ns/1ps
module memory_page_and_space_map_tb_top
   import mem_map_pkg::*;
;
   logic        mclk, reset, table_read, acc_write, acc_bit, acc_miss, op_strobe;
   logic        reg_wr, reg_rd, m;
   logic [15:0] pc, table_addr_in, acc_addr, data_pointer_16;
   logic [17:0] fetch_addr, table_addr;
   logic [7:0]  acc_wdata, acc_rdata, op_code, reg_addr, reg_wdata, reg_rdata, q;
   logic [2:0]  acc_bit_pos;
   access_t     acc_kind;
   int          n_errors, tests_run, i;
   cpu_side_model cpu_u (.mclk(mclk), .acc_rdata(acc_rdata), .acc_miss(acc_miss),
      .pc(pc), .table_read(table_read), .table_addr_in(table_addr_in),
      .acc_kind(acc_kind), .acc_addr(acc_addr), .acc_write(acc_write),
      .acc_bit(acc_bit), .acc_bit_pos(acc_bit_pos), .acc_wdata(acc_wdata),
      .op_strobe(op_strobe), .op_code(op_code));
   mem_page_space_map dut_u (.mclk(mclk), .reset(reset), .pc(pc),
      .fetch_addr(fetch_addr), .table_read(table_read), .table_addr_in(table_addr_in),
      .table_addr(table_addr), .acc_kind(acc_kind), .acc_addr(acc_addr),
      .acc_write(acc_write), .acc_bit(acc_bit), .acc_bit_pos(acc_bit_pos),
      .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_miss(acc_miss),
      .op_strobe(op_strobe), .op_code(op_code), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .data_pointer_16(data_pointer_16));
   // ************************************************
   // clock, checks and command port
   // ************************************************
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      tests_run++;
      if (e !== g)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, e, reg_rdata);
   endtask
   task automatic complete_run();
      if (n_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #50000;
      n_errors++;
      complete_run();
   end
   // ************************************************
   // tests
   // ************************************************
   initial
   begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, n_errors, tests_run} = '0;
      reset = 1'b1;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      rd(OFS_PAGE_CTRL, RST_PAGE_CTRL, "page_ctrl");
      rd(OFS_PAIR_SEL, RST_BYTE, "pair_sel");
      rd(8'h81, 8'h00, "unmapped");
      cpu_u.fetch(16'hBEEF, 1'b0, 16'h0000);
      chk("fetch_p0", {2'b00, 16'hBEEF}, fetch_addr);
      wr(OFS_PAGE_CTRL, 8'h01);
      cpu_u.fetch(16'h1234, 1'b0, 16'h0000);
      chk("fetch_p1", {2'b01, 16'h1234}, fetch_addr);
      rd(OFS_PAGE_CTRL, 8'h01, "page_ctrl");
      for (i = 0; i < 4; i++)
      begin
         wr(OFS_PAGE_CTRL, 8'h08 | 8'(i << 1));
         cpu_u.fetch(16'h4321, 1'b1, 16'hC0DE);
         chk("table", {2'(i), 16'hC0DE}, table_addr);
         chk("fetch_tab", {2'b00, 16'h4321}, fetch_addr);
      end
      cpu_u.fetch(16'h4321, 1'b0, 16'hC0DE);
      chk("table_off", {2'b00, 16'hC0DE}, table_addr);
      cpu_u.access(ACC_EXT_DATA, 16'h1FFF, 1'b1, 8'hAA, q, m);
      cpu_u.access(ACC_EXT_DATA, 16'h1FFF, 1'b0, 8'h00, q, m);
      chk("ext_rd", {1'b0, 8'hAA}, {m, q});
      cpu_u.access(ACC_EXT_DATA, 16'h2000, 1'b0, 8'h00, q, m);
      chk("ext_miss", 1'b1, m);
      wr(OFS_PTR_LOW, 8'h34);
      cpu_u.access(ACC_INDIRECT, 16'h0082, 1'b1, 8'h55, q, m);
      cpu_u.access(ACC_EXT_DATA, 16'h0082, 1'b1, 8'h66, q, m);
      cpu_u.access(ACC_DIRECT, 16'h0082, 1'b0, 8'h00, q, m);
      chk("dir_reg", 8'h34, q);
      cpu_u.set_bit(1'b1, 3'h2);
      cpu_u.access(ACC_DIRECT, 16'h0082, 1'b1, 8'h01, q, m);
      chk("bit_rd", 8'h01, q);
      rd(OFS_PTR_LOW, 8'h34, "bit_wr_refused");
      cpu_u.set_bit(1'b0, 3'h0);
      cpu_u.access(ACC_INDIRECT, 16'h0082, 1'b0, 8'h00, q, m);
      chk("ind_ram", 8'h55, q);
      cpu_u.access(ACC_EXT_DATA, 16'h0082, 1'b0, 8'h00, q, m);
      chk("ext_sep", 8'h66, q);
      cpu_u.access(ACC_DIRECT, 16'h0040, 1'b1, 8'h77, q, m);
      cpu_u.access(ACC_INDIRECT, 16'h0040, 1'b0, 8'h00, q, m);
      chk("dir_ram", 8'h77, q);
      wr(OFS_PAGE_CTRL, 8'h00);
      cpu_u.access(ACC_EXT_DATA, 16'h1FFF, 1'b0, 8'h00, q, m);
      chk("ext_off", {1'b1, 8'h00}, {m, q});
      wr(OFS_PTR_HIGH, 8'h12);
      chk("ptr_std", 16'h1234, data_pointer_16);
      wr(OFS_ALT_LOW, 8'h00);
      wr(OFS_ALT_HIGH, 8'h56);
      wr(OFS_PAIR_SEL, 8'h01);
      chk("ptr_alt", 16'h5600, data_pointer_16);
      cpu_u.op(OP_DEC_POINTER);
      chk("ptr_dec", 16'h55FF, data_pointer_16);
      rd(OFS_ALT_HIGH, 8'h55, "alt_high");
      wr(OFS_PAIR_SEL, 8'h00);
      cpu_u.op(8'h00);
      chk("ptr_nodec", 16'h1234, data_pointer_16);
      complete_run();
   end
endmodule
